// [csof_defs.svh]
/*
  Constants of the colour space output formatter: widths, register map,
  field positions, reset values and timing counts.
  Assumes a 125 MHz core clock and 32-bit AHB-Lite word access.
*/
`ifndef CSOF_DEFS_SVH
`define CSOF_DEFS_SVH

// Datapath widths
`define CSOF_DW 12
`define CSOF_CW 13
`define CSOF_FRAC 12
`define CSOF_ROWS 3
`define CSOF_NCOEF 12

// Pipeline flush length in output data sets
`define CSOF_FLUSH_SETS 6

// Output clock setup after a data change
`define CSOF_CLK_NS 8
`define CSOF_OCLK_SETUP_NS 16
`define CSOF_OCLK_RISE_CYC ((`CSOF_OCLK_SETUP_NS + `CSOF_CLK_NS - 1) / `CSOF_CLK_NS)

// Register byte addresses
`define CSOF_SCALE_ADDR 8'h30
`define CSOF_CTRL_ADDR 8'h34
`define CSOF_STAT_ADDR 8'h38

// Control fields
`define CSOF_CTRL_CSC_EN 0
`define CSOF_CTRL_IN_FMT 1
`define CSOF_CTRL_OUT_MODE 3
`define CSOF_CTRL_OUT_W 5
`define CSOF_CTRL_IN_W 7
`define CSOF_CTRL_RUN 9

// Reset values
`define CSOF_COEF_DIAG 13'h0800
`define CSOF_SCALE_RST 2'h1
`define CSOF_CTRL_RST 10'h000

`endif

// [csof_pkg.sv]
/*
  Types of the colour space output formatter.
  Assumes csof_defs.svh is on the include path.
*/
`include "csof_defs.svh"

package csof_pkg;

  typedef enum logic [1:0] {CSOF_IN_444 = 2'h0, CSOF_IN_422 = 2'h1, CSOF_IN_RGB = 2'h2} csof_in_fmt_t;
  typedef enum logic [1:0] {CSOF_OUT_444 = 2'h0, CSOF_OUT_422 = 2'h1, CSOF_OUT_DUAL = 2'h2} csof_out_mode_t;
  typedef enum logic [1:0] {CSOF_W8 = 2'h0, CSOF_W10 = 2'h1, CSOF_W12 = 2'h2} csof_width_t;
  typedef enum logic [2:0] {CSOF_ST_IDLE = 3'b001, CSOF_ST_FLUSH = 3'b010, CSOF_ST_STREAM = 3'b100} csof_st_t;

  // One pixel: red/Cr, green/Y, blue/Cb and its display enable
  typedef struct packed {
    logic de;
    logic [`CSOF_DW-1:0] r;
    logic [`CSOF_DW-1:0] g;
    logic [`CSOF_DW-1:0] b;
  } csof_pix_t;

endpackage

// [csof_csc_channel.sv]
/*
  One row of the colour matrix: three products, row offset, common
  power-of-two scale, rounding and saturation; two pipeline stages.
  Assumes adv pulses once per pixel and inputs are 12-bit aligned.
*/
`timescale 1ns/1ps
`include "csof_defs.svh"

module csof_csc_channel
  import csof_pkg::*;
#(
  parameter int DW = `CSOF_DW,
  parameter int CW = `CSOF_CW
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adv,
  input wire logic bypass,
  input wire logic [1:0] scale,
  input wire csof_width_t width,
  input wire logic [DW-1:0] pass_in,
  input wire logic [DW-1:0] in_r,
  input wire logic [DW-1:0] in_g,
  input wire logic [DW-1:0] in_b,
  input wire logic signed [CW-1:0] k1,
  input wire logic signed [CW-1:0] k2,
  input wire logic signed [CW-1:0] k3,
  input wire logic signed [CW-1:0] koff,
  output logic [DW-1:0] comp_out
);
  localparam int FRAC = `CSOF_FRAC;
  localparam int PW = CW + DW + 1;
  localparam int SW = PW + 3;
  localparam int XW = SW + 3;

  logic signed [PW-1:0] p1;
  logic signed [PW-1:0] p2;
  logic signed [PW-1:0] p3;
  logic signed [SW-1:0] off_ext;
  logic signed [SW-1:0] sum1;
  logic [DW-1:0] pass1;
  logic signed [XW-1:0] scaled;
  logic signed [XW-1:0] rounded;
  logic [4:0] shift;
  logic [DW-1:0] maxval;
  logic [DW-1:0] next_comp;

  // Signed products; unsigned pixels gain a zero sign bit
  assign p1 = k1 * $signed({1'b0, in_r});
  assign p2 = k2 * $signed({1'b0, in_g});
  assign p3 = k3 * $signed({1'b0, in_b});
  // Offset sits at the product's binary point
  assign off_ext = {{(SW - CW - FRAC){koff[CW-1]}}, koff, {FRAC{1'b0}}};

  // Stage one: weighted sum plus row offset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum1 <= '0;
      pass1 <= '0;
    end else if (adv) begin
      sum1 <= SW'(p1) + SW'(p2) + SW'(p3) + off_ext;
      pass1 <= pass_in;
    end
  end

  // Width select: the binary point drops 12 bits, more for narrow outputs
  always_comb begin
    case (width)
      CSOF_W10: begin
        shift = 5'h0E;
        maxval = 12'h3FF;
      end
      CSOF_W12: begin
        shift = 5'h0C;
        maxval = 12'hFFF;
      end
      default: begin
        shift = 5'h10;
        maxval = 12'h0FF;
      end
    endcase
    scaled = XW'(sum1) <<< scale;
    rounded = (scaled + (XW'(1) <<< (shift - 5'h01))) >>> shift;
    if (bypass)
      next_comp = pass1 >> (shift - 5'h0C);
    else if (rounded[XW-1])
      next_comp = '0;
    else if (rounded > $signed(XW'(maxval)))
      next_comp = maxval;
    else
      next_comp = rounded[DW-1:0];
  end

  // Stage two: one result per pixel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      comp_out <= '0;
    else if (adv)
      comp_out <= next_comp;
  end

  default clocking cb_clk @(posedge clk); endclocking
  default disable iff (!rst_n);

  sat_range_a: assert property ($past(adv) |-> comp_out <= $past(maxval))
    else $error("matrix output above selected width");
  pipe_hold_a: assert property (!$past(adv) |-> $stable(comp_out))
    else $error("matrix output moved without a pixel");
  offset_only_a: assert property (adv && k1 == '0 && k2 == '0 && k3 == '0 |=> sum1 == $past(off_ext))
    else $error("row offset not applied alone");

endmodule // csof_csc_channel

// [csof_chroma_filter.sv]
/*
  4:4:4 to 4:2:2 chroma decimation: a 1-2-1 filter on Cb and Cr, then
  alternate Cb/Cr samples, two pixels of latency.
  Assumes adv pulses once per pixel and de frames the active line.
*/
`timescale 1ns/1ps
`include "csof_defs.svh"

module csof_chroma_filter
  import csof_pkg::*;
#(
  parameter int DW = `CSOF_DW
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adv,
  input wire logic de_in,
  input wire logic [DW-1:0] y_in,
  input wire logic [DW-1:0] cb_in,
  input wire logic [DW-1:0] cr_in,
  output logic de_out,
  output logic phase_out,
  output logic [DW-1:0] y_out,
  output logic [DW-1:0] c_out,
  output logic [DW-1:0] cb_out,
  output logic [DW-1:0] cr_out
);
  logic [DW-1:0] c_in [2];
  logic [DW-1:0] cen [2];
  logic [DW-1:0] filt [2];
  logic de_d1;
  logic de_d2;
  logic ph_d1;
  logic [DW-1:0] y_d1;

  assign c_in[0] = cb_in;
  assign c_in[1] = cr_in;

  // Same three-tap filter on both chroma planes
  for (genvar i = 0; i < 2; i++) begin : g_tap
    logic [DW-1:0] d1;
    logic [DW-1:0] d2;
    logic [DW+1:0] acc;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        d1 <= '0;
        d2 <= '0;
      end else if (adv) begin
        d1 <= c_in[i];
        d2 <= d1;
      end
    end
    // Line edges repeat the centre tap so blanking does not bleed in
    assign acc = (DW+2)'(de_d2 ? d2 : d1) + {1'b0, d1, 1'b0} + (DW+2)'(de_in ? c_in[i] : d1) + (DW+2)'(2);
    assign filt[i] = acc[DW+1:2];
    assign cen[i] = d1;
  end

  // Centre pixel tracking and Cb/Cr phase, restarted at each line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      de_d1 <= 1'b0;
      de_d2 <= 1'b0;
      ph_d1 <= 1'b0;
      y_d1 <= '0;
    end else if (adv) begin
      de_d1 <= de_in;
      de_d2 <= de_d1;
      ph_d1 <= (de_in && de_d1) ? ~ph_d1 : 1'b0;
      y_d1 <= y_in;
    end
  end

  // Registered outputs, all for the centre pixel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      de_out <= 1'b0;
      phase_out <= 1'b0;
      y_out <= '0;
      c_out <= '0;
      cb_out <= '0;
      cr_out <= '0;
    end else if (adv) begin
      de_out <= de_d1;
      phase_out <= ph_d1;
      y_out <= y_d1;
      c_out <= ph_d1 ? filt[1] : filt[0];
      cb_out <= cen[0];
      cr_out <= cen[1];
    end
  end

  default clocking cb_clk @(posedge clk); endclocking
  default disable iff (!rst_n);

  phase_alt_a: assert property (adv && de_in && de_d1 |=> ph_d1 != $past(ph_d1))
    else $error("chroma phase did not alternate");

endmodule // csof_chroma_filter

// [csof_top.sv]
/*
  Colour space output formatter top: AHB-Lite register slave, link
  sampling, input format handling, 3x3 colour matrix, chroma decimation,
  output formatting, flush gating, DE/SAV/EAV markers and output clock.
  Assumes the link clock is much slower than clk (at least 8 clk per period)
  and link data are stable around the link clock's rising edge.
*/
// Functional notes
// - Matrix has three identical channels, each weighting three colour inputs.
// - Coefficients and offsets are 13-bit two's complement; scale is a 2-bit unsigned exponent.
// - Coefficients act as value divided by 4096.
// - Each row adds its own offset to its weighted sum.
// - One shared exponent scales all coefficients and offsets by two to it.
// - Rows use coefficient sets a, b and c in order.
// - Red/Cr, green/Y, blue/Cb feed matrix red, green, blue inputs.
// - Input components of 8, 10 or 12 bits are accepted.
// - One pixel per link clock rise, at most one every two clk cycles; the output clock only rises when sets are at least three clk apart.
// - Accept 444 YCrCb, 422 YCrCb 8/10/12 and RGB input.
// - Output 444 YCrCb 8-bit, 422 at 8/10/12, or dual 422 8-bit.
// - Chroma filter decimates 444 to 422 accurately.
// - RGB input is always converted for YCrCb output.
// - Generate display enable plus start and end of active video marks.
// - Output clock rises between data changes; receiver latches on it.
// - Six data sets precede the first valid data.
`timescale 1ns/1ps
`include "csof_defs.svh"

module csof_top
  import csof_pkg::*;
#(
  parameter int DW = `CSOF_DW,
  parameter int CW = `CSOF_CW,
  parameter int FLUSH_SETS = `CSOF_FLUSH_SETS
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic link_clk,
  input wire logic link_de,
  input wire logic [DW-1:0] link_r,
  input wire logic [DW-1:0] link_g,
  input wire logic [DW-1:0] link_b,
  output logic out_clk,
  output logic out_de,
  output logic out_valid,
  output logic out_sav,
  output logic out_eav,
  output logic [DW-1:0] out_r,
  output logic [DW-1:0] out_g,
  output logic [DW-1:0] out_b
);
  localparam int NCOEF = `CSOF_NCOEF;
  localparam int RISE = `CSOF_OCLK_RISE_CYC;

  logic [1:0] rst_pipe;
  logic rst_n;
  logic take;
  logic wr_pend;
  logic [7:0] bus_addr;
  logic [31:0] next_rdata;
  logic signed [CW-1:0] coef [NCOEF];
  logic [1:0] scale;
  logic [9:0] ctrl;
  logic csc_on;
  logic run;
  csof_in_fmt_t in_fmt;
  csof_out_mode_t out_mode;
  csof_width_t out_w;
  logic [1:0] in_w;
  csof_pix_t pin_s1;
  csof_pix_t pin_s2;
  logic [2:0] lclk_s;
  logic adv;
  logic in_ph;
  logic [DW-1:0] cb_hold;
  logic [DW-1:0] cr_hold;
  logic [DW-1:0] nr;
  logic [DW-1:0] ng;
  logic [DW-1:0] nb;
  logic [DW-1:0] next_cb;
  logic [DW-1:0] next_cr;
  csof_pix_t cap;
  logic [DW-1:0] pass [3];
  logic [DW-1:0] mat_out [3];
  logic [1:0] de_p;
  logic f_de;
  logic f_ph;
  logic [DW-1:0] f_y;
  logic [DW-1:0] f_c;
  logic [DW-1:0] f_cb;
  logic [DW-1:0] f_cr;
  logic pair_t;
  logic odd_now;
  logic emit;
  logic [7:0] y_even;
  logic [7:0] cb_even;
  logic [DW-1:0] next_r;
  logic [DW-1:0] next_g;
  logic [DW-1:0] next_b;
  csof_st_t st;
  csof_st_t next_st;
  logic [3:0] flush_cnt;
  logic last_de;
  logic [1:0] oclk_cnt;
  logic [3:0] seen_sets;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // Bus address phase: whole-word transfers only, other sizes ignored
  assign take = hsel && hready && htrans[1] && hsize == 3'h2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      bus_addr <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      if (take)
        bus_addr <= haddr[7:0];
    end
  end

  // Reads take one wait state so a preceding write is always visible
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !(take && !hwrite);
      hresp <= 1'b0;
      if (!hreadyout)
        hrdata <= next_rdata;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < NCOEF; i++)
      if (bus_addr == 8'(4 * i))
        next_rdata = {19'h0_0000, coef[i]};
    if (bus_addr == `CSOF_SCALE_ADDR)
      next_rdata = {30'h0000_0000, scale};
    if (bus_addr == `CSOF_CTRL_ADDR)
      next_rdata = {22'h00_0000, ctrl};
    if (bus_addr == `CSOF_STAT_ADDR)
      next_rdata = {29'h0000_0000, f_de, st == CSOF_ST_STREAM, pin_s2.de};
  end

  // Coefficient file; rows a, b, c at four words each, offset last
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCOEF; i++)
        coef[i] <= (i == 0 || i == 5 || i == 10) ? `CSOF_COEF_DIAG : 13'h0000;
    end else if (wr_pend) begin
      for (int i = 0; i < NCOEF; i++)
        if (bus_addr == 8'(4 * i))
          coef[i] <= hwdata[CW-1:0];
    end
  end

  // Scale exponent and control word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scale <= `CSOF_SCALE_RST;
      ctrl <= `CSOF_CTRL_RST;
    end else if (wr_pend) begin
      if (bus_addr == `CSOF_SCALE_ADDR)
        scale <= hwdata[1:0];
      if (bus_addr == `CSOF_CTRL_ADDR)
        ctrl <= hwdata[9:0];
    end
  end

  // Control decode; 444 and dual outputs are 8-bit only
  assign run = ctrl[`CSOF_CTRL_RUN];
  assign in_fmt = csof_in_fmt_t'(ctrl[`CSOF_CTRL_IN_FMT +: 2]);
  assign out_mode = csof_out_mode_t'(ctrl[`CSOF_CTRL_OUT_MODE +: 2]);
  assign in_w = ctrl[`CSOF_CTRL_IN_W +: 2];
  assign out_w = (out_mode == CSOF_OUT_422) ? csof_width_t'(ctrl[`CSOF_CTRL_OUT_W +: 2]) : CSOF_W8;
  assign csc_on = ctrl[`CSOF_CTRL_CSC_EN] || in_fmt == CSOF_IN_RGB;

  // Link pins cross into clk through two flops before any use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      lclk_s <= 3'h0;
    end else begin
      pin_s1 <= {link_de, link_r, link_g, link_b};
      pin_s2 <= pin_s1;
      lclk_s <= {lclk_s[1:0], link_clk};
    end
  end
  assign adv = lclk_s[1] && !lclk_s[2];

  // Narrow inputs are scaled up to the 12-bit matrix range
  function automatic logic [DW-1:0] norm(input logic [DW-1:0] x, input logic [1:0] w);
    case (w)
      2'h1: norm = x << 2;
      2'h2: norm = x;
      default: norm = x << 4;
    endcase
  endfunction

  // Port routing; 422 input carries Cb then Cr on the red port
  always_comb begin
    nr = norm(pin_s2.r, in_w);
    ng = norm(pin_s2.g, in_w);
    nb = norm(pin_s2.b, in_w);
    next_cb = nb;
    next_cr = nr;
    if (in_fmt == CSOF_IN_422) begin
      next_cb = in_ph ? cb_hold : nr;
      next_cr = in_ph ? nr : cr_hold;
    end
  end

  // Pixel capture; held chroma lags one pixel, a cheap 422 upsample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap <= '0;
      in_ph <= 1'b0;
      cb_hold <= '0;
      cr_hold <= '0;
    end else if (adv) begin
      cap <= {pin_s2.de, next_cr, ng, next_cb};
      if (!in_ph)
        cb_hold <= nr;
      else
        cr_hold <= nr;
      in_ph <= (pin_s2.de && in_fmt == CSOF_IN_422) ? ~in_ph : 1'b0;
    end
  end

  assign pass[0] = cap.r;
  assign pass[1] = cap.g;
  assign pass[2] = cap.b;

  // Three matrix rows; bypass keeps the same latency as conversion
  for (genvar k = 0; k < 3; k++) begin : g_row
    csof_csc_channel #(.DW(DW), .CW(CW)) u_ch (
      .clk(clk),
      .rst_n(rst_n),
      .adv(adv),
      .bypass(!csc_on),
      .scale(scale),
      .width(out_w),
      .pass_in(pass[k]),
      .in_r(cap.r),
      .in_g(cap.g),
      .in_b(cap.b),
      .k1(coef[4*k]),
      .k2(coef[4*k+1]),
      .k3(coef[4*k+2]),
      .koff(coef[4*k+3]),
      .comp_out(mat_out[k])
    );
  end

  // Display enable follows the matrix pipeline
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      de_p <= 2'h0;
    else if (adv)
      de_p <= {de_p[0], cap.de};
  end

  csof_chroma_filter #(.DW(DW)) u_flt (
    .clk(clk),
    .rst_n(rst_n),
    .adv(adv),
    .de_in(de_p[1]),
    .y_in(mat_out[1]),
    .cb_in(mat_out[2]),
    .cr_in(mat_out[0]),
    .de_out(f_de),
    .phase_out(f_ph),
    .y_out(f_y),
    .c_out(f_c),
    .cb_out(f_cb),
    .cr_out(f_cr)
  );

  // Dual mode emits one set per pixel pair, paced in blanking too
  assign odd_now = f_de ? f_ph : pair_t;
  assign emit = adv && (out_mode != CSOF_OUT_DUAL || odd_now);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pair_t <= 1'b0;
      y_even <= 8'h00;
      cb_even <= 8'h00;
    end else if (adv) begin
      pair_t <= ~odd_now;
      if (!odd_now) begin
        y_even <= f_y[7:0];
        cb_even <= f_c[7:0];
      end
    end
  end

  // Output packing per mode
  always_comb begin
    next_r = f_cr;
    next_g = f_y;
    next_b = f_cb;
    case (out_mode)
      CSOF_OUT_422: begin
        next_r = f_c;
        next_b = '0;
      end
      CSOF_OUT_DUAL: begin
        next_r = {4'h0, cb_even};
        next_g = {f_c[7:4], y_even};
        next_b = {f_c[3:0], f_y[7:0]};
      end
      default: ;
    endcase
  end

  // Flush sequencer: sets are withheld from validity until flushed
  always_comb begin
    next_st = st;
    unique case (st)
      CSOF_ST_IDLE: if (run) next_st = CSOF_ST_FLUSH;
      CSOF_ST_FLUSH: begin
        if (!run)
          next_st = CSOF_ST_IDLE;
        else if (emit && flush_cnt == 4'(FLUSH_SETS - 1))
          next_st = CSOF_ST_STREAM;
      end
      CSOF_ST_STREAM: if (!run) next_st = CSOF_ST_IDLE;
      default: next_st = CSOF_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= CSOF_ST_IDLE;
      flush_cnt <= 4'h0;
    end else begin
      st <= next_st;
      if (st != CSOF_ST_FLUSH)
        flush_cnt <= 4'h0;
      else if (emit)
        flush_cnt <= flush_cnt + 4'h1;
    end
  end

  // Output data, validity and active video marks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= '0;
      out_g <= '0;
      out_b <= '0;
      out_valid <= 1'b0;
      out_de <= 1'b0;
      out_sav <= 1'b0;
      out_eav <= 1'b0;
      last_de <= 1'b0;
    end else if (emit) begin
      out_r <= next_r;
      out_g <= next_g;
      out_b <= next_b;
      out_valid <= st == CSOF_ST_STREAM;
      out_de <= st == CSOF_ST_STREAM && f_de;
      out_sav <= st == CSOF_ST_STREAM && f_de && !last_de;
      out_eav <= st == CSOF_ST_STREAM && !f_de && last_de;
      last_de <= st == CSOF_ST_STREAM && f_de;
    end
  end

  // Output clock drops with each data change and rises after setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_clk <= 1'b0;
      oclk_cnt <= 2'h0;
    end else if (emit) begin
      out_clk <= 1'b0;
      oclk_cnt <= 2'h0;
    end else if (!out_clk) begin
      if (oclk_cnt == 2'(RISE - 1))
        out_clk <= 1'b1;
      else
        oclk_cnt <= oclk_cnt + 2'h1;
    end
  end

  // Helper: sets emitted since leaving idle, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      seen_sets <= 4'h0;
    else if (st == CSOF_ST_IDLE)
      seen_sets <= 4'h0;
    else if (emit && seen_sets != 4'hF)
      seen_sets <= seen_sets + 4'h1;
  end

  default clocking cb_clk @(posedge clk); endclocking
  default disable iff (!rst_n);

  oclk_low_a: assert property ($changed({out_r, out_g, out_b, out_de}) |-> !out_clk)
    else $error("output data changed with clock high");
  oclk_rise_a: assert property ($rose(out_clk) |-> $stable({out_r, out_g, out_b}) && !$past(out_clk, 2))
    else $error("output clock rose without setup");
  flush_gate_a: assert property ($rose(out_valid) |-> seen_sets > FLUSH_SETS)
    else $error("valid data before pipeline flush");
  de_valid_a: assert property (out_de |-> out_valid)
    else $error("display enable on invalid data");
  sav_mark_a: assert property ($rose(out_de) |-> out_sav)
    else $error("start of active video missing");
  eav_mark_a: assert property ($fell(out_de) && out_valid |-> out_eav)
    else $error("end of active video missing");
  bus_ok_a: assert property ((!hreadyout |=> hreadyout) and !hresp)
    else $error("bus response not single wait OKAY");

endmodule // csof_top

// [csof_rx_model.sv]
/* Downstream receiver model: latches each output set on the output clock's
   rising edge and counts them. Assumes clr is high while the bench reconfigures. */
`timescale 1ns/1ps
`include "csof_defs.svh"
module csof_rx_model
  import csof_pkg::*;
(
  input wire logic clr,
  input wire logic out_clk,
  input wire logic out_de,
  input wire logic out_valid,
  input wire logic out_sav,
  input wire logic out_eav,
  input wire logic [`CSOF_DW-1:0] out_r,
  input wire logic [`CSOF_DW-1:0] out_g,
  input wire logic [`CSOF_DW-1:0] out_b,
  output int n_lead,
  output int n_de,
  output int n_sav,
  output int n_eav,
  output logic [`CSOF_DW-1:0] first_r,
  output logic [`CSOF_DW-1:0] second_r,
  output logic [`CSOF_DW-1:0] last_g,
  output logic [`CSOF_DW-1:0] last_b
);
  logic seen;
  // Latch on the rise only, the one moment data are promised stable
  always @(posedge out_clk or posedge clr) begin
    if (clr) begin
      seen = 1'b0;
      n_lead = 0;
      n_de = 0;
      n_sav = 0;
      n_eav = 0;
    end else if (!out_valid && !seen) begin
      n_lead = n_lead + 1; // leading sets discarded
    end else begin
      seen = 1'b1;
      n_sav = n_sav + int'(out_sav);
      n_eav = n_eav + int'(out_eav);
      if (out_de) begin
        if (n_de == 0) first_r = out_r;
        if (n_de == 1) second_r = out_r;
        last_g = out_g;
        last_b = out_b;
        n_de = n_de + 1;
      end
    end
  end
endmodule // csof_rx_model

// [color_space_output_formatter_tb.sv]
/* Self-checking bench of the formatter top: registers over AHB-Lite, one
   video line per pass. Assumes the design and receiver model are compiled. */
`timescale 1ns/1ps
`include "csof_defs.svh"
module color_space_output_formatter_tb
  import csof_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, rx_clr = 1'b1;
  logic link_clk = 1'b0, link_de = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, wd;
  logic [1:0] htrans = 2'h0, sc;
  logic [2:0] hsize = 3'h2;
  logic [11:0] link_r = 12'h0, link_g = 12'h0, link_b = 12'h0, out_r, out_g, out_b, f_r, s_r, l_g, l_b;
  logic hreadyout, hresp, out_clk, out_de, out_valid, out_sav, out_eav;
  int n_errors = 0, total_checks = 0, n_lead, n_de, n_sav, n_eav;
  logic [12:0] k [12];
  logic [11:0] px [3];
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h30, 8'h34, 8'h3C};
  logic [31:0] re [5] = '{32'h800, 32'h0, 32'h1, 32'h0, 32'h0};

  // Core clock, 125 MHz
  always #4 clk = ~clk;

  csof_top i_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .link_clk(link_clk), .link_de(link_de), .link_r(link_r), .link_g(link_g), .link_b(link_b),
    .out_clk(out_clk), .out_de(out_de), .out_valid(out_valid), .out_sav(out_sav), .out_eav(out_eav),
    .out_r(out_r), .out_g(out_g), .out_b(out_b));
  csof_rx_model i_rx (.clr(rx_clr), .out_clk(out_clk), .out_de(out_de), .out_valid(out_valid),
    .out_sav(out_sav), .out_eav(out_eav), .out_r(out_r), .out_g(out_g), .out_b(out_b), .n_lead(n_lead),
    .n_de(n_de), .n_sav(n_sav), .n_eav(n_eav), .first_r(f_r), .second_r(s_r), .last_g(l_g), .last_b(l_b));

  task final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Ends at the rising edge that samples hreadyout high; bounded
  task wait_rdy();
    int i;
    i = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        chk(1'b0, "bus hang");
        final_report();
      end
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  // One single word transfer; read data land in rd
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // One link pixel of 20 core cycles, data steady across the rise
  task pix(input logic de);
    link_de <= de;
    link_r <= px[0];
    link_g <= px[1];
    link_b <= px[2];
    link_clk <= 1'b0;
    repeat (10) @(posedge clk);
    link_clk <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
  // Expected matrix row: weighted sum, offset, scale, rounding, clamp
  function automatic logic [11:0] mx(input int row);
    longint v;
    v = longint'($signed(k[4 * row + 3])) * 4096;
    for (int i = 0; i < 3; i++) v += longint'($signed(k[4 * row + i])) * longint'(px[i]);
    v = ((v << sc) + 2048) >>> 12;
    return (v < 0) ? 12'h000 : (v > 4095) ? 12'hFFF : v[11:0];
  endfunction

  initial begin
    repeat (100000) @(posedge clk);
    chk(1'b0, "run timeout");
    final_report();
  end

  initial begin
    void'($urandom(32'h0F737EBF));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ra[i]) begin
      ahb(1'b0, ra[i], 32'h0);
      chk(rd === re[i], "reset value");
    end
    // Pass 0 converts YCrCb, pass 1 RGB with matrix enable off, pass 2 bypasses 8-bit 444
    for (int it = 0; it < 3; it++) begin
      sc = 2'($urandom_range(2));
      foreach (k[i]) begin
        wd = $urandom;
        // Pass 1 zeroes the row 0 weights so only its offset remains
        k[i] = (it == 1 && i < 3) ? 13'h0000 : wd[12:0];
        ahb(1'b1, 8'(4 * i), {wd[31:13], k[i]});
      end
      foreach (k[i]) begin
        ahb(1'b0, 8'(4 * i), 32'h0);
        chk(rd === {19'h0, k[i]}, "coefficient readback");
      end
      ahb(1'b1, 8'h30, {30'h0, sc});
      foreach (px[i]) px[i] = 12'($urandom);
      rx_clr <= 1'b1;
      ahb(1'b1, 8'h34, 32'h0);
      ahb(1'b1, 8'h34, (it == 2) ? 32'h200 : (it == 1) ? 32'h34C : 32'h349);
      rx_clr <= 1'b0;
      repeat (8) pix(1'b0);
      repeat (8) pix(1'b1);
      repeat (10) pix(1'b0);
      chk(n_lead == `CSOF_FLUSH_SETS, "leading set count");
      chk(n_de == 8 && n_sav == 1 && n_eav == 1, "marker counts");
      chk(l_g === ((it == 2) ? {4'h0, px[1][7:0]} : mx(1)), "luma row");
      chk(f_r === ((it == 2) ? {4'h0, px[0][7:0]} : mx(2)), "chroma order first");
      chk(s_r === ((it == 2) ? {4'h0, px[0][7:0]} : mx(0)), "chroma order second");
      chk(l_b === ((it == 2) ? {4'h0, px[2][7:0]} : 12'h000), "blue port");
    end
    final_report();
  end
endmodule // color_space_output_formatter_tb
